/* File: cable_plant_model.sv */
// Cable plant with a far partner sending on its own pair
`timescale 1ns/100ps
`default_nettype none
module cable_plant_model
  import phy_ext_ctrl_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  cableCross,
  output logic       rxEnergyA,
  output logic       rxEnergyB,
  output line_pair_t pairAIn,
  output line_pair_t pairBIn
);
  line_pair_t sym_q = 2'h1;
  always @(posedge core_clk) sym_q <= {sym_q.neg, ~sym_q.pos};
  assign rxEnergyA = cableCross;
  assign rxEnergyB = !cableCross;
  assign pairAIn = cableCross ? sym_q : ~sym_q;
  assign pairBIn = cableCross ? ~sym_q : sym_q;
endmodule : cable_plant_model
`default_nettype wire

/* File: crossover_hunt.sv */
// Automatic crossover hunt: toggles pair assignment until energy appears on the receive pair
`timescale 1ns/100ps
`default_nettype none
module crossover_hunt
  import phy_ext_ctrl_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic autoActive,
  input  wire logic rxEnergyA,
  input  wire logic rxEnergyB,
  output logic      autoCross_q
);

  logic [HUNT_CNT_W-1:0] dwell_q;
  logic                  rxEnergySeen;

  // Straight receives on pair B, cross receives on pair A
  assign rxEnergySeen = autoCross_q ? rxEnergyA : rxEnergyB;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !autoActive || rxEnergySeen) begin
      dwell_q <= '0;
    end else if (dwell_q == HUNT_CNT_W'(HUNT_CYCLES - 1)) begin
      dwell_q <= '0;
    end else begin
      dwell_q <= dwell_q + HUNT_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !autoActive) begin
      autoCross_q <= ASSIGN_STRAIGHT;
    end else if (!rxEnergySeen && dwell_q == HUNT_CNT_W'(HUNT_CYCLES - 1)) begin
      autoCross_q <= ~autoCross_q;
    end
  end

endmodule : crossover_hunt
`default_nettype wire

/* File: phy_ext_ctrl_assertions.sv */
// Checks for extended control register two
`timescale 1ns/100ps
`default_nettype none
module phy_ext_ctrl_assertions
  import phy_ext_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] mgmtAddr,
  input wire logic mgmtWrite,
  input wire logic mgmtRead,
  input wire logic [15:0] mgmtWdata,
  input wire logic [15:0] mgmtRdata_q,
  input wire logic mgmtRvalid_q,
  input wire logic crossStrap,
  input wire logic remoteFaultRx,
  input wire logic pairAOe_n_q,
  input wire logic pairBOe_n_q,
  input wire logic sqeTestEnable_q,
  input wire logic pairCross_q,
  input wire logic autoCrossActive_q
);
  logic [15:0] shadow_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) shadow_q <= EXT_CTRL_RESET;
    else if (mgmtWrite && mgmtAddr == EXT_CTRL_TWO)
      shadow_q <= shadow_q & ~EXT_CTRL_WMASK | mgmtWdata & EXT_CTRL_WMASK;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence regRead;
    mgmtRead && mgmtAddr == EXT_CTRL_TWO;
  endsequence
  sqe_on_a: assert property (sqeTestEnable_q)
    else $error("sqe off");
  read_answer_a: assert property (mgmtRead |=> mgmtRvalid_q)
    else $error("no answer");
  read_data_a: assert property (regRead |=> mgmtRdata_q ==
    {$past(shadow_q[15:14]), $past(remoteFaultRx), $past(shadow_q[12:0])}) else $error("rdata");
  forced_pair_a: assert property (!$past(sys_rst) && !$past(shadow_q[9]) |->
    pairCross_q == $past(shadow_q[8])) else $error("forced pair");
  strap_straight_a: assert property (!$past(sys_rst) && $past(shadow_q[9] && !crossStrap) |->
    !pairCross_q) else $error("strap pair");
  auto_active_a: assert property (!$past(sys_rst) |->
    autoCrossActive_q == $past(crossStrap && shadow_q[9])) else $error("auto flag");
  float_pair_a: assert property (!$past(sys_rst) && $past(shadow_q[7]) |->
    pairAOe_n_q && pairBOe_n_q) else $error("not floated");
  one_driver_a: assert property (!$past(sys_rst) && !$past(shadow_q[7]) |->
    pairAOe_n_q != pairBOe_n_q) else $error("pair drive");
endmodule : phy_ext_ctrl_assertions
bind phy_extended_control_crossover phy_ext_ctrl_assertions u_phy_ext_ctrl_assertions (
  .core_clk          (core_clk),
  .sys_rst           (sys_rst),
  .mgmtAddr          (mgmtAddr),
  .mgmtWrite         (mgmtWrite),
  .mgmtRead          (mgmtRead),
  .mgmtWdata         (mgmtWdata),
  .mgmtRdata_q       (mgmtRdata_q),
  .mgmtRvalid_q      (mgmtRvalid_q),
  .crossStrap        (crossStrap),
  .remoteFaultRx     (remoteFaultRx),
  .pairAOe_n_q       (pairAOe_n_q),
  .pairBOe_n_q       (pairBOe_n_q),
  .sqeTestEnable_q   (sqeTestEnable_q),
  .pairCross_q       (pairCross_q),
  .autoCrossActive_q (autoCrossActive_q)
);
`default_nettype wire

/* File: phy_ext_ctrl_pkg.sv */
// Package: register map, field layout and timing for extended control register two
package phy_ext_ctrl_pkg;

  localparam int          MGMT_ADDR_W     = 5;
  localparam int          REG_W           = 16;
  localparam logic [4:0]  EXT_CTRL_TWO    = 5'h13;
  localparam logic [15:0] EXT_CTRL_RESET  = 16'h4201;
  // Bits that software may change: 12, 11, 9, 8, 7 and 6..0
  localparam logic [15:0] EXT_CTRL_WMASK  = 16'h1BFF;
  localparam logic        NODE_MODE_VAL   = 1'b0;
  localparam logic        SW_MODE_VAL     = 1'b1;
  localparam logic        SQE_TEST_RESET  = 1'b1;
  localparam logic        ASSIGN_STRAIGHT = 1'b0;

  // Crossover hunt dwell per pair assignment
  localparam int HUNT_TIME_NS    = 1000;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int HUNT_CYCLES     = HUNT_TIME_NS / CLK_PERIOD_NS;
  localparam int HUNT_CNT_W      = $clog2(HUNT_CYCLES + 1);

  typedef struct packed {
    logic       nodeRepeater;
    logic       softwareMode;
    logic       remoteFault;
    logic [2:0] reservedHigh;
    logic       crossover_auto_enable;
    logic       pair_assignment_select;
    logic       pair_output_float;
    logic [5:0] reservedLow;
    logic       autoPowerDown100;
  } ext_ctrl_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

endpackage : phy_ext_ctrl_pkg

/* File: phy_extended_control_crossover.sv */
// Extended control register two with crossover, line float and 100M power-down control
`timescale 1ns/100ps
`default_nettype none
// Function
// - Register at address 0x13; bit 15 reads 0
// - Carrier sense on transmit or receive activity
// - Test pulse generation enabled after reset
// - Bit 14 reads 1, software configuration
// - Bit 13 mirrors partner remote fault
// - Auto crossover swaps pairs to match cable
// - Bit 9 low forces assignment from bit 8
// - Strap low with bit 9 forces straight
// - Auto only when strap and bit 9 high
// - Straight transmits A, receives B; cross swaps
// - Auto crossover on by default after reset
// - Bit 7 floats line transmit outputs
// - Bit 0 powers down 100M at 10M
// - Isolate also powers down 100M transceiver
module phy_extended_control_crossover
  import phy_ext_ctrl_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [MGMT_ADDR_W-1:0] mgmtAddr,
  input  wire logic                   mgmtWrite,
  input  wire logic                   mgmtRead,
  input  wire logic [REG_W-1:0]       mgmtWdata,
  output logic      [REG_W-1:0]       mgmtRdata_q,
  output logic                        mgmtRvalid_q,
  input  wire logic                   crossStrap,
  input  wire logic                   remoteFaultRx,
  input  wire logic                   txActive,
  input  wire logic                   rxActive,
  input  wire logic                   speed10,
  input  wire logic                   isolate,
  input  wire logic                   rxEnergyA,
  input  wire logic                   rxEnergyB,
  input  wire line_pair_t             lineTx,
  input  wire line_pair_t             pairAIn,
  input  wire line_pair_t             pairBIn,
  output line_pair_t                  pairAOut_q,
  output line_pair_t                  pairBOut_q,
  output logic                        pairAOe_n_q,
  output logic                        pairBOe_n_q,
  output line_pair_t                  lineRx_q,
  output logic                        carrierSense_q,
  output logic                        sqeTestEnable_q,
  output logic                        pairCross_q,
  output logic                        autoCrossActive_q,
  output logic                        powerDown100_q
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  ext_ctrl_t ctrl_q;
  ext_ctrl_t ctrlView;
  logic      regHit;
  logic      autoActive;
  logic      autoCross;
  logic      cross_d;
  logic      lineFloat;
  logic      autoPowerDown;

  assign regHit = (mgmtAddr == EXT_CTRL_TWO);

  // Writes to any other address are ignored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= ext_ctrl_t'(EXT_CTRL_RESET);
    end else if (mgmtWrite && regHit) begin
      // Read-only fields keep their value
      ctrl_q <= ext_ctrl_t'((mgmtWdata & EXT_CTRL_WMASK)
                            | (REG_W'(ctrl_q) & ~EXT_CTRL_WMASK));
    end
  end

  // Status bits are substituted at read time, never stored
  always_comb begin
    ctrlView              = ctrl_q;
    ctrlView.nodeRepeater = NODE_MODE_VAL;
    ctrlView.softwareMode = SW_MODE_VAL;
    ctrlView.remoteFault  = remoteFaultRx;
    ctrlView.reservedHigh[0] = 1'b0;
  end

  // Answer every read strobe one cycle later, mapped address or not
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mgmtRvalid_q <= 1'b0;
    end else begin
      mgmtRvalid_q <= mgmtRead;
    end
  end

  // Unmapped addresses and idle cycles return zero data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mgmtRdata_q <= '0;
    end else begin
      mgmtRdata_q <= (mgmtRead && regHit) ? REG_W'(ctrlView) : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crossover selection

  // Hunt runs only when both the strap and bit 9 allow it
  assign autoActive = crossStrap && ctrl_q.crossover_auto_enable;

  // Hunt restarts from straight whenever auto selection is off
  crossover_hunt u_hunt (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .autoActive  (autoActive),
    .rxEnergyA   (rxEnergyA),
    .rxEnergyB   (rxEnergyB),
    .autoCross_q (autoCross)
  );

  // Bit 9 low overrides the strap; strap low overrides the hunt
  always_comb begin
    if (!ctrl_q.crossover_auto_enable) begin
      cross_d = ctrl_q.pair_assignment_select;
    end else if (!crossStrap) begin
      cross_d = ASSIGN_STRAIGHT;
    end else begin
      cross_d = autoCross;
    end
  end

  // Registered pair assignment, 1 = cross
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pairCross_q <= ASSIGN_STRAIGHT;
    end else begin
      pairCross_q <= cross_d;
    end
  end

  // Reports that the strap and bit 9 both allow the hunt
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      autoCrossActive_q <= 1'b0;
    end else begin
      autoCrossActive_q <= autoActive;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line pair routing and float

  // Float acts on the transmit pair through its enable only
  assign lineFloat = ctrl_q.pair_output_float;

  // Transmit data goes to one pair; the other pair is held at zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pairAOut_q <= '0;
      pairBOut_q <= '0;
    end else begin
      pairAOut_q <= cross_d ? line_pair_t'('0) : lineTx;
      pairBOut_q <= cross_d ? lineTx : line_pair_t'('0);
    end
  end

  // Enables are active low; both pairs float while in reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pairAOe_n_q <= 1'b1;
      pairBOe_n_q <= 1'b1;
    end else begin
      pairAOe_n_q <= cross_d || lineFloat;
      pairBOe_n_q <= !cross_d || lineFloat;
    end
  end

  // Receive data comes from whichever pair is not transmitting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lineRx_q <= '0;
    end else begin
      lineRx_q <= cross_d ? pairAIn : pairBIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Node behaviour and power-down

  // Node configuration only: carrier follows either direction
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      carrierSense_q <= 1'b0;
    end else begin
      carrierSense_q <= txActive || rxActive;
    end
  end

  // Test pulse generation stays enabled in node configuration
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sqeTestEnable_q <= SQE_TEST_RESET;
    end else begin
      sqeTestEnable_q <= SQE_TEST_RESET;
    end
  end

  // Automatic power-down applies only at 10 Mb/s; isolate always wins
  assign autoPowerDown = ctrl_q.autoPowerDown100 && speed10;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerDown100_q <= 1'b0;
    end else begin
      powerDown100_q <= autoPowerDown || isolate;
    end
  end

endmodule : phy_extended_control_crossover
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for extended control register two
`timescale 1ns/100ps
`default_nettype none
module tb;
  import phy_ext_ctrl_pkg::*;
  logic core_clk = 0, sys_rst = 1, mgmtWrite = 0, mgmtRead = 0, crossStrap = 1, cableCross = 0;
  logic remoteFaultRx = 0, txActive = 0, rxActive = 0, speed10 = 0, isolate = 0, x;
  logic mgmtRvalid_q, rxEnergyA, rxEnergyB, pairAOe_n_q, pairBOe_n_q, carrierSense_q;
  logic sqeTestEnable_q, pairCross_q, autoCrossActive_q, powerDown100_q;
  logic [4:0] mgmtAddr = 0;
  logic [15:0] mgmtWdata = 0, mgmtRdata_q, m;
  line_pair_t lineTx = 0, pairAIn, pairBIn, pairAOut_q, pairBOut_q, lineRx_q;
  int bad_count = 0, checked = 0, cyc = 0;
  line_pair_t rxSeen;
  phy_extended_control_crossover u_phy_extended_control_crossover (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .mgmtAddr          (mgmtAddr),
    .mgmtWrite         (mgmtWrite),
    .mgmtRead          (mgmtRead),
    .mgmtWdata         (mgmtWdata),
    .mgmtRdata_q       (mgmtRdata_q),
    .mgmtRvalid_q      (mgmtRvalid_q),
    .crossStrap        (crossStrap),
    .remoteFaultRx     (remoteFaultRx),
    .txActive          (txActive),
    .rxActive          (rxActive),
    .speed10           (speed10),
    .isolate           (isolate),
    .rxEnergyA         (rxEnergyA),
    .rxEnergyB         (rxEnergyB),
    .lineTx            (lineTx),
    .pairAIn           (pairAIn),
    .pairBIn           (pairBIn),
    .pairAOut_q        (pairAOut_q),
    .pairBOut_q        (pairBOut_q),
    .pairAOe_n_q       (pairAOe_n_q),
    .pairBOe_n_q       (pairBOe_n_q),
    .lineRx_q          (lineRx_q),
    .carrierSense_q    (carrierSense_q),
    .sqeTestEnable_q   (sqeTestEnable_q),
    .pairCross_q       (pairCross_q),
    .autoCrossActive_q (autoCrossActive_q),
    .powerDown100_q    (powerDown100_q)
  );
  cable_plant_model u_cable_plant_model (
    .core_clk   (core_clk),
    .cableCross (cableCross),
    .rxEnergyA  (rxEnergyA),
    .rxEnergyB  (rxEnergyB),
    .pairAIn    (pairAIn),
    .pairBIn    (pairBIn)
  );
  // What the far partner put on its sending pair at the last edge
  always @(posedge core_clk) rxSeen <= cableCross ? pairAIn : pairBIn;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 20000) begin
    cmp(16'h0, 16'h1);
    tally_and_finish();
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic [4:0] a, input logic [15:0] wd, input logic w);
    @(posedge core_clk);
    #1;
    {mgmtAddr, mgmtWdata, mgmtWrite, mgmtRead} = {a, wd, w, !w};
    @(posedge core_clk);
    #1;
    {mgmtWrite, mgmtRead} = 2'h0;
    if (w && a == EXT_CTRL_TWO) m = m & ~EXT_CTRL_WMASK | wd & EXT_CTRL_WMASK;
  endtask : acc
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    acc(a, 16'h0, 1'b0);
    cmp({mgmtRvalid_q, mgmtRdata_q}, {1'b1, exp});
  endtask : rd
  task automatic tally_and_finish;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'hF7B8));
    m = EXT_CTRL_RESET;
    repeat (4) @(posedge core_clk);
    #1;
    sys_rst = 0;
    rd(EXT_CTRL_TWO, 16'h4201);
    cmp({autoCrossActive_q, pairCross_q}, 2'h2);
    for (int i = 0; i < 60; i++) begin
      {crossStrap, remoteFaultRx, txActive, rxActive, speed10, isolate, lineTx} = 8'($urandom);
      acc(i % 5 ? EXT_CTRL_TWO : 5'h12, 16'($urandom) & 16'hE381, 1'b1);
      rd(EXT_CTRL_TWO, m & 16'hDFFF | 16'(remoteFaultRx) << 13);
      x = !m[9] & m[8];
      cmp(autoCrossActive_q, m[9] & crossStrap);
      if (!(m[9] & crossStrap)) cmp({pairCross_q, pairAOe_n_q, pairBOe_n_q}, {x, m[7] | x, m[7] | !x});
      cmp({powerDown100_q, carrierSense_q, sqeTestEnable_q}, {m[0] & speed10 | isolate, txActive | rxActive, 1'b1});
    end
    sys_rst = 1;
    repeat (2) @(posedge core_clk);
    #1;
    cmp({pairAOe_n_q, pairBOe_n_q, pairCross_q, autoCrossActive_q}, 4'hC);
    cmp({sqeTestEnable_q, powerDown100_q, carrierSense_q, mgmtRvalid_q, lineRx_q}, 6'h20);
    sys_rst = 0;
    m = EXT_CTRL_RESET;
    rd(EXT_CTRL_TWO, m | 16'(remoteFaultRx) << 13);
    rd(5'h12, 16'h0);
    {crossStrap, cableCross} = 2'h3;
    acc(EXT_CTRL_TWO, 16'h0201, 1'b1);
    repeat (600) @(posedge core_clk);
    #1;
    cmp({pairCross_q, pairBOe_n_q, pairBOut_q, lineRx_q}, {1'b1, 1'b0, lineTx, rxSeen});
    cableCross = 0;
    repeat (600) @(posedge core_clk);
    #1;
    cmp({pairCross_q, pairAOe_n_q, pairAOut_q, lineRx_q}, {2'h0, lineTx, rxSeen});
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
